// File: core/sub_borrow_alu.sv
// combinational subtract-with-borrow arithmetic and flag generation
`timescale 1ns/10ps
module sub_borrow_alu
  import sub_borrow_pkg::*;
(
  // operands
  input  wire logic [DATA_W-1:0] file_val_i,
  input  wire logic [DATA_W-1:0] work_val_i,
  input  wire logic              carry_i,
  // result and flags
  output logic      [DATA_W-1:0] result_o,
  output logic                   carry_o,
  output logic                   half_carry_flag_o,
  output logic                   signed_overflow_flag_o,
  output logic                   zero_o,
  output logic                   negative_o
);
  logic [DATA_W:0]   full_diff;
  logic [NIBBLE_W:0] low_diff;
  logic              borrow_in;

  // cleared carry means a borrow is pending
  assign borrow_in = ~carry_i;
  assign full_diff = {1'b0, file_val_i} - {1'b0, work_val_i} - {{DATA_W{1'b0}}, borrow_in};
  assign low_diff  = {1'b0, file_val_i[NIBBLE_W-1:0]} - {1'b0, work_val_i[NIBBLE_W-1:0]}
                   - {{NIBBLE_W{1'b0}}, borrow_in};

  assign result_o               = full_diff[DATA_W-1:0];
  assign carry_o                = ~full_diff[DATA_W];
  assign half_carry_flag_o      = ~low_diff[NIBBLE_W];
  assign signed_overflow_flag_o = (file_val_i[DATA_W-1] != work_val_i[DATA_W-1])
                               && (result_o[DATA_W-1] != file_val_i[DATA_W-1]);
  assign zero_o                 = (result_o == '0);
  assign negative_o             = result_o[DATA_W-1];
endmodule : sub_borrow_alu

// File: core/sub_borrow_exec.sv
// four-phase execution of the subtract-work-from-file-with-borrow instruction
`timescale 1ns/10ps
module sub_borrow_exec
  import sub_borrow_pkg::*;
(
  // clock and reset
  input  wire logic               mclk_i,
  input  wire logic               resetn_i,
  // instruction from decoder
  input  wire logic               instr_valid_i,
  input  wire logic [INSTR_W-1:0] instr_word_i,
  output logic                    ready_o,
  // core state
  input  wire logic               ext_set_en_i,
  input  wire logic [BANK_W-1:0]  bank_select_reg_i,
  input  wire logic [ADDR_W-1:0]  index_base_i,
  input  wire logic [DATA_W-1:0]  work_reg_i,
  input  wire logic               carry_i,
  // data memory
  output logic      [ADDR_W-1:0]  file_addr_o,
  output logic                    file_rd_o,
  input  wire logic [DATA_W-1:0]  file_rdata_i,
  output logic                    file_wr_o,
  // results
  output logic      [DATA_W-1:0]  result_o,
  output logic                    work_wr_o,
  output logic                    flags_wr_o,
  output logic                    carry_o,
  output logic                    half_carry_flag_o,
  output logic                    signed_overflow_flag_o,
  output logic                    zero_o,
  output logic                    negative_o
);
  ////////////////////////////////////////////////////////////////
  // address mapping
  function automatic logic [ADDR_W-1:0] map_addr(input logic             bank_sel,
                                                  input logic             ext_en,
                                                  input logic [FADDR_MSB:0] faddr,
                                                  input logic [BANK_W-1:0] bank_select_reg,
                                                  input logic [ADDR_W-1:0] base);
    logic [ADDR_W-1:0] addr;
    addr = {bank_select_reg, faddr};
    if (!bank_sel && ext_en && (faddr <= INDEX_LIMIT)) begin
      addr = base + {{(ADDR_W-FADDR_MSB-1){1'b0}}, faddr};
    end else if (!bank_sel) begin
      addr = {(faddr < ACCESS_SPLIT) ? ACCESS_LO_BANK : ACCESS_HI_BANK, faddr};
    end
    return addr;
  endfunction : map_addr

  ////////////////////////////////////////////////////////////////
  // state and decode
  phase_t              phase_ff;
  phase_t              nxt_phase;
  logic [INSTR_W-1:0]  instr_ff;
  logic [DATA_W-1:0]   alu_result;
  logic                alu_c;
  logic                alu_dc;
  logic                alu_ov;
  logic                alu_z;
  logic                alu_n;
  logic                opc_match;
  logic                dest_file;
  logic [ADDR_W-1:0]   nxt_addr;

  // other opcodes are not ours and are left to the rest of the core
  assign opc_match = (instr_word_i[OPC_MSB:OPC_LSB] == OPC_SUB_BORROW);
  assign dest_file = instr_ff[DEST_BIT];
  assign nxt_addr  = map_addr(instr_ff[BANK_BIT], ext_set_en_i, instr_ff[FADDR_MSB:0],
                              bank_select_reg_i, index_base_i);

  always_comb begin
    nxt_phase = phase_ff;
    case (phase_ff)
      PH_IDLE:    nxt_phase = (instr_valid_i && opc_match) ? PH_DECODE : PH_IDLE;
      PH_DECODE:  nxt_phase = PH_READ;
      PH_READ:    nxt_phase = PH_PROCESS;
      PH_PROCESS: nxt_phase = PH_WRITE;
      PH_WRITE:   nxt_phase = PH_IDLE;
      default:    nxt_phase = PH_IDLE;
    endcase
  end

  sub_borrow_alu u_alu (
    .file_val_i             (file_rdata_i),
    .work_val_i             (work_reg_i),
    .carry_i                (carry_i),
    .result_o               (alu_result),
    .carry_o                (alu_c),
    .half_carry_flag_o      (alu_dc),
    .signed_overflow_flag_o (alu_ov),
    .zero_o                 (alu_z),
    .negative_o             (alu_n)
  );

  ////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      phase_ff <= PH_IDLE;
      instr_ff <= '0;
      ready_o  <= 1'b0;
    end else begin
      phase_ff <= nxt_phase;
      ready_o  <= (nxt_phase == PH_IDLE);
      if (phase_ff == PH_IDLE && instr_valid_i && opc_match) begin
        instr_ff <= instr_word_i;
      end
    end
  end

  // memory read strobe stands in the read phase; data returns one cycle later
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      file_addr_o <= '0;
      file_rd_o   <= 1'b0;
    end else begin
      file_rd_o <= (phase_ff == PH_DECODE);
      if (phase_ff == PH_DECODE) begin
        file_addr_o <= nxt_addr;
      end
    end
  end

  // operands sampled in the process phase, so work and carry must be stable then
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      result_o               <= '0;
      carry_o                <= 1'b0;
      half_carry_flag_o      <= 1'b0;
      signed_overflow_flag_o <= 1'b0;
      zero_o                 <= 1'b0;
      negative_o             <= 1'b0;
    end else if (phase_ff == PH_PROCESS) begin
      result_o               <= alu_result;
      carry_o                <= alu_c;
      half_carry_flag_o      <= alu_dc;
      signed_overflow_flag_o <= alu_ov;
      zero_o                 <= alu_z;
      negative_o             <= alu_n;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      file_wr_o  <= 1'b0;
      work_wr_o  <= 1'b0;
      flags_wr_o <= 1'b0;
    end else begin
      file_wr_o  <= (phase_ff == PH_PROCESS) && dest_file;
      work_wr_o  <= (phase_ff == PH_PROCESS) && !dest_file;
      flags_wr_o <= (phase_ff == PH_PROCESS);
    end
  end

  ////////////////////////////////////////////////////////////////
  // checks
  sequence s_phases;
    phase_ff == PH_READ ##1 phase_ff == PH_PROCESS ##1 phase_ff == PH_WRITE ##1 phase_ff == PH_IDLE;
  endsequence

  sequence s_write_strobe;
    !file_rd_o ##1 file_rd_o ##1 !file_rd_o ##1 flags_wr_o;
  endsequence

  property p_phase_walk;
    @(posedge mclk_i) disable iff (!resetn_i)
    phase_ff == PH_DECODE |=> s_phases;
  endproperty
  a_phase_walk: assert property (p_phase_walk) else $error("phase order broken");

  property p_strobes;
    @(posedge mclk_i) disable iff (!resetn_i)
    phase_ff == PH_IDLE && instr_valid_i && opc_match |=> s_write_strobe;
  endproperty
  a_strobes: assert property (p_strobes) else $error("read or write strobe misplaced");

  property p_decode;
    @(posedge mclk_i) disable iff (!resetn_i)
    phase_ff == PH_IDLE && instr_valid_i |=> (phase_ff == PH_DECODE) == $past(opc_match);
  endproperty
  a_decode: assert property (p_decode) else $error("opcode decode wrong");

  property p_dest;
    @(posedge mclk_i) disable iff (!resetn_i)
    phase_ff == PH_PROCESS |=> (file_wr_o == $past(instr_ff[DEST_BIT])) && (work_wr_o != file_wr_o);
  endproperty
  a_dest: assert property (p_dest) else $error("destination select wrong");

  property p_arith;
    @(posedge mclk_i) disable iff (!resetn_i)
    phase_ff == PH_PROCESS |=> result_o == $past(DATA_W'(file_rdata_i - work_reg_i - DATA_W'(!carry_i)));
  endproperty
  a_arith: assert property (p_arith) else $error("difference wrong");

  property p_carry;
    @(posedge mclk_i) disable iff (!resetn_i)
    phase_ff == PH_PROCESS |=>
      carry_o == $past({1'b0, file_rdata_i} >= ({1'b0, work_reg_i} + 9'(!carry_i))) && zero_o == (result_o == '0);
  endproperty
  a_carry: assert property (p_carry) else $error("carry or zero wrong");

  property p_bank;
    @(posedge mclk_i) disable iff (!resetn_i)
    phase_ff == PH_DECODE && instr_ff[BANK_BIT] |=> file_addr_o == {$past(bank_select_reg_i), $past(instr_ff[7:0])};
  endproperty
  a_bank: assert property (p_bank) else $error("bank select address wrong");

  property p_index;
    @(posedge mclk_i) disable iff (!resetn_i)
    phase_ff == PH_DECODE && !instr_ff[BANK_BIT] && ext_set_en_i && instr_ff[7:0] <= INDEX_LIMIT
      |=> file_addr_o == $past(index_base_i) + ADDR_W'($past(instr_ff[7:0]));
  endproperty
  a_index: assert property (p_index) else $error("indexed address wrong");

  // plain access bank: offsets below ACCESS_SPLIT (0x60) map to bank zero, the rest to the top bank
  property p_access;
    @(posedge mclk_i) disable iff (!resetn_i)
    phase_ff == PH_DECODE && !instr_ff[BANK_BIT]
      && !(ext_set_en_i && instr_ff[FADDR_MSB:0] <= INDEX_LIMIT)
      |=> file_addr_o[FADDR_MSB:0] == $past(instr_ff[FADDR_MSB:0])
          && file_addr_o[ADDR_W-1:FADDR_MSB+1]
             == (($past(instr_ff[FADDR_MSB:0]) < ACCESS_SPLIT) ? ACCESS_LO_BANK : ACCESS_HI_BANK);
  endproperty
  a_access: assert property (p_access) else $error("access bank address wrong");
endmodule : sub_borrow_exec

// File: inc/sub_borrow_pkg.sv
// constants for the subtract-with-borrow execution block
package sub_borrow_pkg;
  // instruction word layout
  localparam int          INSTR_W        = 16;
  localparam int          OPC_MSB        = 15;
  localparam int          OPC_LSB        = 10;
  localparam int          DEST_BIT       = 9;
  localparam int          BANK_BIT       = 8;
  localparam int          FADDR_MSB      = 7;
  localparam logic [5:0]  OPC_SUB_BORROW = 6'h16;
  // data memory addressing
  localparam int          DATA_W         = 8;
  localparam int          BANK_W         = 4;
  localparam int          ADDR_W         = 12;
  localparam logic [7:0]  INDEX_LIMIT    = 8'h5f;
  localparam logic [7:0]  ACCESS_SPLIT   = 8'h60;
  localparam logic [3:0]  ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0]  ACCESS_HI_BANK = 4'hf;
  localparam int          NIBBLE_W       = 4;
  // one-hot phase codes
  typedef enum logic [4:0] {
    PH_IDLE    = 5'h01,
    PH_DECODE  = 5'h02,
    PH_READ    = 5'h04,
    PH_PROCESS = 5'h08,
    PH_WRITE   = 5'h10
  } phase_t;
endpackage : sub_borrow_pkg

// File: tb/testbench.sv
// self-checking bench for the subtract-with-borrow execution block
`timescale 1ns/10ps
module testbench
  import sub_borrow_pkg::*;
;
  typedef struct {logic [11:0] addr; logic [7:0] res; logic [4:0] flg; logic d; int tk;} exp_t;
  logic               mclk_i            = 1'b0;
  logic               resetn_i          = 1'b0;
  logic               instr_valid_i     = 1'b0;
  logic [INSTR_W-1:0] instr_word_i      = 16'h0000;
  logic               ext_set_en_i      = 1'b0;
  logic [BANK_W-1:0]  bank_select_reg_i = 4'h0;
  logic [ADDR_W-1:0]  index_base_i      = 12'h000;
  logic [DATA_W-1:0]  work_reg_i        = 8'h00;
  logic               carry_i           = 1'b0;
  logic [DATA_W-1:0]  file_rdata_i      = 8'h00;
  logic               ready_o, file_rd_o, file_wr_o, work_wr_o, flags_wr_o;
  logic               carry_o, half_carry_flag_o, signed_overflow_flag_o, zero_o, negative_o;
  logic [ADDR_W-1:0]  file_addr_o;
  logic [DATA_W-1:0]  result_o;
  exp_t               exp_q[$];
  exp_t               m;
  int                 err_count = 0;
  int                 compares  = 0;
  int                 cyc       = 0;

  sub_borrow_exec dut_u (.mclk_i(mclk_i), .resetn_i(resetn_i), .instr_valid_i(instr_valid_i),
    .instr_word_i(instr_word_i), .ready_o(ready_o), .ext_set_en_i(ext_set_en_i),
    .bank_select_reg_i(bank_select_reg_i), .index_base_i(index_base_i), .work_reg_i(work_reg_i),
    .carry_i(carry_i), .file_addr_o(file_addr_o), .file_rd_o(file_rd_o), .file_rdata_i(file_rdata_i),
    .file_wr_o(file_wr_o), .result_o(result_o), .work_wr_o(work_wr_o), .flags_wr_o(flags_wr_o),
    .carry_o(carry_o), .half_carry_flag_o(half_carry_flag_o),
    .signed_overflow_flag_o(signed_overflow_flag_o), .zero_o(zero_o), .negative_o(negative_o));

  always #5 mclk_i = ~mclk_i;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] expv);
    compares++;
    if (seen !== expv) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask : check

  task automatic summarize();
    if (err_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize

  // expectation is noted at the take edge; operands stay put until the next issue
  task automatic issue(input logic [5:0] opc, input logic d, input logic a, input logic ext,
                       input logic [7:0] f, input logic [7:0] w, input logic [7:0] fv,
                       input logic c, input int hold);
    exp_t e;
    logic [8:0] df;
    logic [4:0] dl;
    logic [3:0] bank_select_reg;
    logic [11:0] ib;
    int n;
    n = 0;
    bank_select_reg = 4'($urandom);
    ib = 12'($urandom);
    @(posedge mclk_i);
    while (ready_o !== 1'b1 && n < 50) begin
      @(posedge mclk_i);
      n++;
    end
    instr_valid_i <= 1'b1;
    instr_word_i <= {opc, d, a, f};
    ext_set_en_i <= ext;
    bank_select_reg_i <= bank_select_reg;
    index_base_i <= ib;
    work_reg_i <= w;
    carry_i <= c;
    file_rdata_i <= fv;
    df = {1'b0, fv} - {1'b0, w} - {8'h00, ~c};
    dl = {1'b0, fv[3:0]} - {1'b0, w[3:0]} - {4'h0, ~c};
    e.res = df[7:0];
    e.flg = {~df[8], ~dl[4], (fv[7] != w[7]) && (df[7] != fv[7]), df[7:0] == 8'h00, df[7]};
    e.d = d;
    if (a) e.addr = {bank_select_reg, f};
    else if (ext && f <= INDEX_LIMIT) e.addr = ib + {4'h0, f};
    else if (f < ACCESS_SPLIT) e.addr = {ACCESS_LO_BANK, f};
    else e.addr = {ACCESS_HI_BANK, f};
    @(posedge mclk_i);
    e.tk = cyc;
    if (opc == OPC_SUB_BORROW) exp_q.push_back(e);
    repeat (hold) @(posedge mclk_i);
    instr_valid_i <= 1'b0;
  endtask : issue

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_count++;
      summarize();
    end
  end

  // outputs are registered, so the falling edge sees them settled
  always @(negedge mclk_i) begin
    if (resetn_i === 1'b1 && file_rd_o === 1'b1) begin
      if (exp_q.size() == 0) check(16'h1, 16'h0);
      else begin
        check(16'(file_addr_o), 16'(exp_q[0].addr));
        check(16'(cyc - exp_q[0].tk), 16'h2);
        check(16'(ready_o), 16'h0);
      end
    end
    if (resetn_i === 1'b1 && flags_wr_o === 1'b1) begin
      if (exp_q.size() == 0) check(16'h1, 16'h0);
      else begin
        m = exp_q.pop_front();
        check(16'(result_o), 16'(m.res));
        check(16'({carry_o, half_carry_flag_o, signed_overflow_flag_o, zero_o, negative_o}), 16'(m.flg));
        check(16'({work_wr_o, file_wr_o}), 16'({~m.d, m.d}));
        check(16'(cyc - m.tk), 16'h4);
        check(16'(ready_o), 16'h0);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(23079));
    repeat (4) @(posedge mclk_i);
    resetn_i <= 1'b1;
    issue(OPC_SUB_BORROW, 1'b1, 1'b0, 1'b1, 8'h5f, 8'h0d, 8'h19, 1'b1, 0);
    issue(OPC_SUB_BORROW, 1'b0, 1'b0, 1'b1, 8'h60, 8'h1a, 8'h1b, 1'b0, 0);
    issue(OPC_SUB_BORROW, 1'b1, 1'b1, 1'b1, 8'h10, 8'h0e, 8'h03, 1'b1, 2);
    issue(6'h17, 1'b1, 1'b0, 1'b0, 8'h20, 8'h01, 8'h02, 1'b1, 3);
    issue(OPC_SUB_BORROW, 1'b0, 1'b0, 1'b0, 8'h5f, 8'h80, 8'h7f, 1'b0, 1);
    for (int i = 0; i < 150; i++) begin
      issue(($urandom % 8 == 0) ? 6'h17 : OPC_SUB_BORROW, 1'($urandom), 1'($urandom), 1'($urandom),
            8'($urandom), 8'($urandom), 8'($urandom), 1'($urandom), $urandom % 3);
    end
    repeat (10) @(posedge mclk_i);
    check(16'(exp_q.size()), 16'h0);
    summarize();
  end
endmodule : testbench
